//--- hl2ig_defs.svh
// hl2ig_defs.svh: offsets, field positions, reset values and limits for
// the second data-link interrupt gating block.
// assumes: included by bare name into the package and the top module.
`ifndef HL2IG_DEFS_SVH
`define HL2IG_DEFS_SVH

// ============================================================
// register byte offsets on the 32-bit register bus
`define HL2IG_ADDR_W 8
`define HL2IG_OFS_LINK_EN 8'h00
`define HL2IG_OFS_LINK_STAT 8'h04
`define HL2IG_OFS_OVS_STAT 8'h08
`define HL2IG_OFS_OVS_EN 8'h0C

// ============================================================
// data-link field positions, shared by enable and status
`define HL2IG_NSRC 7
`define HL2IG_BIT_TX_BEGIN 6
`define HL2IG_BIT_RX_BEGIN 5
`define HL2IG_BIT_TX_DONE 4
`define HL2IG_BIT_RX_DONE 3
`define HL2IG_BIT_CHECKSUM 2
`define HL2IG_BIT_ABORT 1
`define HL2IG_BIT_IDLE 0
`define HL2IG_BIT_OVS 0

// ============================================================
// reset values and limits
`define HL2IG_LINK_EN_RST 7'h00
`define HL2IG_OVS_EN_RST 1'h0
`define HL2IG_OVS_LIMIT 16'h0114
`define HL2IG_RESP_OKAY 2'h0
`define HL2IG_RESP_DECERR 2'h3

`endif

//--- hl2ig_pkg.sv
// hl2ig_pkg.sv: types for the data-link interrupt gating block.
// assumes: hl2ig_defs.svh sits in the same folder.
`include "hl2ig_defs.svh"

package hl2ig_pkg;

    // ========================================================
    // bus channel states, one-hot
    typedef enum logic [1:0] {
        HL2IG_WR_IDLE = 2'h1,
        HL2IG_WR_RESP = 2'h2
    } hl2ig_wr_t;

    typedef enum logic [1:0] {
        HL2IG_RD_IDLE = 2'h1,
        HL2IG_RD_DATA = 2'h2
    } hl2ig_rd_t;

    // ========================================================
    // whole state of the top module
    typedef struct packed {
        hl2ig_wr_t wr_state;
        hl2ig_rd_t rd_state;
        logic aw_held;
        logic [`HL2IG_ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [`HL2IG_NSRC-1:0] link_en;
        logic [`HL2IG_NSRC-1:0] link_stat;
        logic ovs_en;
        logic ovs_stat;
        logic irq;
    } hl2ig_state_t;

endpackage : hl2ig_pkg

//--- hl2ig_top.sv
// hl2ig_top.sv: interrupt enable and status logic of the second data-link
// controller pair, with an AXI4-Lite register slave.
// assumes: event inputs are one-cycle pulses synchronous to aclk, driven
// by the transmit and receive engines, which live outside this block.
//
// How it works
// R1: tx begin event gated by its enable
// R2: rx begin event gated by its enable
// R3: tx done event gated by its enable
// R4: rx done event gated by its enable
// R5: checksum error event gated by its enable
// R6: abort sequence event gated by its enable
// R7: idle flag event gated by its enable
// R8: enables read-write, 0 off, reset to 0
// R9: message over 276 bytes sets oversize flag
// R10: oversize flag clears when its register read
// R11: separate enable gates oversize interrupt
// R12: link status bits latch, clear on read
// R13: rx done also set by full buffer
// R14: irq high while enabled flag set
`timescale 1ns/10ps

`include "hl2ig_defs.svh"

module hl2ig_top
    import hl2ig_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,

    // register bus, write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [`HL2IG_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,

    // write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,

    // write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,

    // read address channel
    input wire logic arvalid,
    output logic arready,
    input wire logic [`HL2IG_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,

    // read data channel
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,

    // events from the transmit controller
    input wire logic tx_begin_evt,
    input wire logic tx_done_evt,

    // events from the receive controller
    input wire logic rx_begin_evt,
    input wire logic rx_done_evt,
    input wire logic rx_buf_full_evt,
    input wire logic checksum_error_evt,
    input wire logic abort_seen_evt,
    input wire logic idle_flag_seen_evt,

    // message accepted by the receive controller, with its byte length
    input wire logic rx_msg_accept,
    input wire logic [15:0] rx_msg_len,

    // single level interrupt request
    output logic irq
);

    // ============================================================
    // timing at the ports, counted in aclk edges
    // reset: awready, wready and arready rise at the first edge after
    //   release; every other output stays low until something happens
    // write: address and data are taken in either order; the edge
    //   after both are held carries the write out and raises bvalid
    // write: awready and wready stay low from their own handshake to
    //   the edge that takes the response
    // read: the edge that takes the address raises rvalid with
    //   the data; arready returns at the edge that takes the data
    // a read of a status register clears it at the address handshake;
    //   rdata shows the value from just before that clear
    // status writes: both status offsets answer OKAY and ignore data,
    //   so only a read clears a flag
    // events: a pulse high at an edge sets its flag at that edge, and
    //   irq follows at the same edge when the source is enabled
    // limitation: a level held on an event input sets its flag again
    //   every cycle, so a read cannot clear it while the level stays
    // limitation: only byte lane 0 holds fields; a write with its
    //   lane 0 strobe low is answered OKAY and changes nothing
    // oversize: a length equal to the limit is legal; one byte more
    //   sets the flag
    // trade-off: irq is built from next-state values to save a cycle
    //   of latency, at the cost of a longer path into its flop

    // ============================================================
    // state registers
    hl2ig_state_t st_r;
    hl2ig_state_t st_nxt;

    // ============================================================
    // event vector in status-bit order
    // pulses arrive already in the aclk domain from the engines,
    // so no synchroniser stands in front of them
    logic [`HL2IG_NSRC-1:0] link_evt;
    logic ovs_evt;

    // each source feeds the bit of the same position in the status
    assign link_evt[`HL2IG_BIT_TX_BEGIN] = tx_begin_evt; // R1
    assign link_evt[`HL2IG_BIT_RX_BEGIN] = rx_begin_evt; // R2
    assign link_evt[`HL2IG_BIT_TX_DONE] = tx_done_evt; // R3
    // a full buffer ends reception just like a complete message
    assign link_evt[`HL2IG_BIT_RX_DONE] = rx_done_evt | rx_buf_full_evt; // R4 R13
    assign link_evt[`HL2IG_BIT_CHECKSUM] = checksum_error_evt; // R5
    assign link_evt[`HL2IG_BIT_ABORT] = abort_seen_evt; // R6
    assign link_evt[`HL2IG_BIT_IDLE] = idle_flag_seen_evt; // R7

    // strictly longer than the limit; exactly at the limit is legal
    assign ovs_evt = rx_msg_accept && (rx_msg_len > `HL2IG_OVS_LIMIT); // R9

    // ============================================================
    // address decode helpers
    logic wr_hit_link_en;
    logic wr_hit_link_stat;
    logic wr_hit_ovs_stat;
    logic wr_hit_ovs_en;
    logic rd_hit_link_en;
    logic rd_hit_link_stat;
    logic rd_hit_ovs_stat;
    logic rd_hit_ovs_en;
    logic wr_mapped;
    logic rd_mapped;

    // byte offsets compared whole: the low two bits must be zero
    assign wr_hit_link_en = (st_r.aw_addr == `HL2IG_OFS_LINK_EN);
    assign wr_hit_link_stat = (st_r.aw_addr == `HL2IG_OFS_LINK_STAT);
    assign wr_hit_ovs_stat = (st_r.aw_addr == `HL2IG_OFS_OVS_STAT);
    assign wr_hit_ovs_en = (st_r.aw_addr == `HL2IG_OFS_OVS_EN);
    assign rd_hit_link_en = (araddr == `HL2IG_OFS_LINK_EN);
    assign rd_hit_link_stat = (araddr == `HL2IG_OFS_LINK_STAT);
    assign rd_hit_ovs_stat = (araddr == `HL2IG_OFS_OVS_STAT);
    assign rd_hit_ovs_en = (araddr == `HL2IG_OFS_OVS_EN);

    // status registers answer OKAY to a write but ignore it
    // unmapped offsets answer DECERR and touch nothing
    assign wr_mapped = wr_hit_link_en | wr_hit_link_stat |
                       wr_hit_ovs_stat | wr_hit_ovs_en;
    assign rd_mapped = rd_hit_link_en | rd_hit_link_stat |
                       rd_hit_ovs_stat | rd_hit_ovs_en;

    // ============================================================
    // handshake helpers
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_fire;
    logic clr_link;
    logic clr_ovs;

    assign aw_take = awvalid & st_r.awready;
    assign w_take = wvalid & st_r.wready;
    assign ar_take = arvalid & st_r.arready;

    // a write is carried out once both address and data are held
    assign wr_fire = (st_r.wr_state == HL2IG_WR_IDLE) &&
                     st_r.aw_held && st_r.w_held;

    // the clear rides on the read handshake itself
    assign clr_link = ar_take & rd_hit_link_stat; // R12
    assign clr_ovs = ar_take & rd_hit_ovs_stat; // R10

    // ============================================================
    // per-bit sticky flag update, one term per status bit
    // each bit sees only its own event and the shared clear strobe
    logic [`HL2IG_NSRC-1:0] link_stat_upd;

    genvar gi;
    generate
        for (gi = 0; gi < `HL2IG_NSRC; gi++) begin : g_flag
            // an event in the clearing cycle survives: set wins
            assign link_stat_upd[gi] =
                (st_r.link_stat[gi] & ~clr_link) | link_evt[gi]; // R12
        end
    endgenerate

    // ============================================================
    // next-state logic: bus slave, flags, enables, interrupt
    always_comb begin
        st_nxt = st_r;

        // -------- write address and data capture --------
        // either may arrive first; each is held until the write fires
        if (aw_take) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = awaddr;
        end
        if (w_take) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = wdata[7:0];
            st_nxt.w_lane0 = wstrb[0];
        end

        // -------- write execution and response --------
        // decode uses the held address, never the live bus
        unique case (st_r.wr_state)
            HL2IG_WR_IDLE: begin
                if (wr_fire) begin
                    // only byte lane 0 carries fields; other lanes drop
                    if (wr_hit_link_en && st_r.w_lane0) begin
                        st_nxt.link_en =
                            st_r.w_data[`HL2IG_NSRC-1:0]; // R8
                    end
                    if (wr_hit_ovs_en && st_r.w_lane0) begin
                        st_nxt.ovs_en = st_r.w_data[`HL2IG_BIT_OVS]; // R11
                    end
                    st_nxt.aw_held = 1'b0;
                    st_nxt.w_held = 1'b0;
                    st_nxt.bvalid = 1'b1;
                    st_nxt.bresp = wr_mapped ? `HL2IG_RESP_OKAY :
                                               `HL2IG_RESP_DECERR;
                    st_nxt.wr_state = HL2IG_WR_RESP;
                end
            end
            HL2IG_WR_RESP: begin
                if (bready) begin
                    st_nxt.bvalid = 1'b0;
                    st_nxt.bresp = `HL2IG_RESP_OKAY;
                    st_nxt.wr_state = HL2IG_WR_IDLE;
                end
            end
        endcase

        // each ready stays low while its own half of the write is still held
        st_nxt.awready = ~st_nxt.aw_held &&
                         (st_nxt.wr_state == HL2IG_WR_IDLE);
        st_nxt.wready = ~st_nxt.w_held &&
                        (st_nxt.wr_state == HL2IG_WR_IDLE);

        // -------- read channel --------
        // one read at a time: arready stays low until rdata is taken
        unique case (st_r.rd_state)
            HL2IG_RD_IDLE: begin
                if (ar_take) begin
                    // snapshot taken before this cycle's clear
                    st_nxt.rdata = 32'h0000_0000;
                    if (rd_hit_link_en) begin
                        st_nxt.rdata[`HL2IG_NSRC-1:0] = st_r.link_en; // R8
                    end
                    if (rd_hit_link_stat) begin
                        st_nxt.rdata[`HL2IG_NSRC-1:0] = st_r.link_stat;
                    end
                    if (rd_hit_ovs_stat) begin
                        st_nxt.rdata[`HL2IG_BIT_OVS] = st_r.ovs_stat; // R10
                    end
                    if (rd_hit_ovs_en) begin
                        st_nxt.rdata[`HL2IG_BIT_OVS] = st_r.ovs_en; // R11
                    end
                    st_nxt.rresp = rd_mapped ? `HL2IG_RESP_OKAY :
                                               `HL2IG_RESP_DECERR;
                    st_nxt.rvalid = 1'b1;
                    st_nxt.arready = 1'b0;
                    st_nxt.rd_state = HL2IG_RD_DATA;
                end
            end
            HL2IG_RD_DATA: begin
                if (rready) begin
                    st_nxt.rvalid = 1'b0;
                    st_nxt.rdata = 32'h0000_0000;
                    st_nxt.rresp = `HL2IG_RESP_OKAY;
                    st_nxt.arready = 1'b1;
                    st_nxt.rd_state = HL2IG_RD_IDLE;
                end
            end
        endcase

        // arready comes up the first cycle out of reset
        if (st_r.rd_state == HL2IG_RD_IDLE && !st_r.rvalid &&
            !st_r.arready) begin
            st_nxt.arready = 1'b1;
        end

        // -------- sticky status flags --------
        // an event in the clearing cycle survives: set wins over clear
        st_nxt.link_stat = link_stat_upd; // R12
        st_nxt.ovs_stat = (st_r.ovs_stat & ~clr_ovs) | ovs_evt; // R9 R10

        // -------- interrupt request --------
        // built from next values so irq tracks flags in the same edge
        st_nxt.irq = (|(st_nxt.link_stat & st_nxt.link_en)) |
                     (st_nxt.ovs_stat & st_nxt.ovs_en); // R14 R11
    end

    // ============================================================
    // state register, synchronous active-low reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r.wr_state <= HL2IG_WR_IDLE;
            st_r.rd_state <= HL2IG_RD_IDLE;
            st_r.aw_held <= 1'b0;
            st_r.aw_addr <= 8'h00;
            st_r.w_held <= 1'b0;
            st_r.w_data <= 8'h00;
            st_r.w_lane0 <= 1'b0;
            st_r.awready <= 1'b0;
            st_r.wready <= 1'b0;
            st_r.bvalid <= 1'b0;
            st_r.bresp <= `HL2IG_RESP_OKAY;
            st_r.arready <= 1'b0;
            st_r.rvalid <= 1'b0;
            st_r.rdata <= 32'h0000_0000;
            st_r.rresp <= `HL2IG_RESP_OKAY;
            st_r.link_en <= `HL2IG_LINK_EN_RST; // R8
            st_r.link_stat <= 7'h00;
            st_r.ovs_en <= `HL2IG_OVS_EN_RST;
            st_r.ovs_stat <= 1'b0;
            st_r.irq <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ============================================================
    // outputs straight from the state register
    assign awready = st_r.awready;
    assign wready = st_r.wready;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign arready = st_r.arready;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;
    assign irq = st_r.irq;

endmodule : hl2ig_top

//--- hl2ig_chk.sv
// hl2ig_chk.sv: port-level assertions for the interrupt gating block.
// assumes: bound to hl2ig_top; enables shadowed from bus writes.
`timescale 1ns/10ps
`include "hl2ig_defs.svh"

module hl2ig_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [`HL2IG_ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [`HL2IG_ADDR_W-1:0] araddr,
    input wire logic tx_begin_evt,
    input wire logic tx_done_evt,
    input wire logic rx_begin_evt,
    input wire logic rx_done_evt,
    input wire logic rx_buf_full_evt,
    input wire logic checksum_error_evt,
    input wire logic abort_seen_evt,
    input wire logic idle_flag_seen_evt,
    input wire logic rx_msg_accept,
    input wire logic [15:0] rx_msg_len,
    input wire logic irq
);
    logic [7:0] a_r;
    logic [7:0] d_r;
    logic s_r;
    logic aw_h_r;
    logic w_h_r;
    logic land;
    logic [6:0] en_r;
    logic oen_r;
    logic [6:0] en_now;
    logic oen_now;
    logic quiet;

    // ========================================================
    // enable shadow: a write lands at the edge after both halves
    // are held, the same edge that raises bvalid
    assign land = aw_h_r && w_h_r && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_h_r <= 1'h0;
            w_h_r <= 1'h0;
            a_r <= 8'h00;
            d_r <= 8'h00;
            s_r <= 1'h0;
            en_r <= 7'h00;
            oen_r <= 1'h0;
        end else begin
            if (awvalid && awready) begin
                aw_h_r <= 1'h1;
                a_r <= awaddr;
            end
            if (wvalid && wready) begin
                w_h_r <= 1'h1;
                d_r <= wdata[7:0];
                s_r <= wstrb[0];
            end
            if (land) begin
                aw_h_r <= 1'h0;
                w_h_r <= 1'h0;
                en_r <= en_now;
                oen_r <= oen_now;
            end
        end
    end

    // enables in force at this edge, a landing write included
    assign en_now = (land && s_r && a_r == `HL2IG_OFS_LINK_EN) ?
        d_r[6:0] : en_r;
    assign oen_now = (land && s_r && a_r == `HL2IG_OFS_OVS_EN) ?
        d_r[0] : oen_r;

    // no event may land in a cycle whose clear is checked
    assign quiet = !(tx_begin_evt | tx_done_evt | rx_begin_evt |
        rx_done_evt | rx_buf_full_evt | checksum_error_evt |
        abort_seen_evt | idle_flag_seen_evt | rx_msg_accept);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_TX_BEGIN: assert property (tx_begin_evt && en_now[6] |=> irq)
        else $error("tx begin irq");
    AST_RX_BEGIN: assert property (rx_begin_evt && en_now[5] |=> irq)
        else $error("rx begin irq");
    AST_TX_DONE: assert property (tx_done_evt && en_now[4] |=> irq)
        else $error("tx done irq");
    AST_RX_DONE: assert property (rx_done_evt && en_now[3] |=> irq)
        else $error("rx done irq");
    AST_CKS: assert property (checksum_error_evt && en_now[2] |=> irq)
        else $error("checksum irq");
    AST_ABORT: assert property (abort_seen_evt && en_now[1] |=> irq)
        else $error("abort irq");
    AST_IDLE: assert property (idle_flag_seen_evt && en_now[0] |=> irq)
        else $error("idle irq");
    AST_FULL: assert property (rx_buf_full_evt && en_now[3] |=> irq)
        else $error("buffer full irq");
    AST_OVS: assert property (rx_msg_accept &&
        rx_msg_len > `HL2IG_OVS_LIMIT && oen_now |=> irq)
        else $error("oversize irq");
    AST_GATE: assert property (en_r == 7'h00 && !oen_r |-> !irq)
        else $error("irq while all disabled");
    AST_LINK_CLR: assert property (arvalid && arready && quiet &&
        araddr == `HL2IG_OFS_LINK_STAT && !oen_now |=> !irq)
        else $error("link status not cleared");
    AST_OVS_CLR: assert property (arvalid && arready && quiet &&
        araddr == `HL2IG_OFS_OVS_STAT && en_now == 7'h00 |=> !irq)
        else $error("oversize flag not cleared");
endmodule : hl2ig_chk

bind hl2ig_top hl2ig_chk i_chk (.*);

//--- hdlc_link2_interrupt_gating_tb_top.sv
// testbench for the second data-link interrupt gating block.
// assumes: the bench alone drives the register bus and event pulses.
`timescale 1ns/10ps
`include "hl2ig_defs.svh"

module hdlc_link2_interrupt_gating_tb_top;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, full = 1'h0, acc = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [6:0] ev = 7'h00;
    logic [15:0] len = 16'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int failures = 0;
    int comparisons = 0;

    // ========================================================
    // device under test, protection bits unused by the block
    hl2ig_top i_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .tx_begin_evt(ev[6]), .rx_begin_evt(ev[5]), .tx_done_evt(ev[4]),
        .rx_done_evt(ev[3]), .checksum_error_evt(ev[2]),
        .abort_seen_evt(ev[1]), .idle_flag_seen_evt(ev[0]),
        .rx_buf_full_evt(full), .rx_msg_accept(acc), .rx_msg_len(len),
        .irq(irq));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // handshakes judged mid-cycle, where the next edge will sample them
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'hF, input logic [1:0] er = 2'h0);
        logic ha, hw, hb;
        logic [1:0] r;
        int n;
        n = 0;
        @(posedge aclk);
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        do begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 1'h0;
            if (hw) wvalid <= 1'h0;
            if (hb) bready <= 1'h0;
            n++;
        end while (!hb && n < 50);
        chk({31'h0, hb}, 32'h1);
        chk({30'h0, r}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        logic h, v;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        @(posedge aclk);
        arvalid <= 1'h1;
        rready <= 1'h1;
        araddr <= a;
        do begin
            @(negedge aclk);
            h = arvalid && arready;
            v = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (h) arvalid <= 1'h0;
            if (v) rready <= 1'h0;
            n++;
        end while (!v && n < 50);
        chk({31'h0, v}, 32'h1);
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask : rd

    // one-cycle events; a nonzero length also accepts a message
    task automatic pulse(input logic [6:0] m, input logic f,
        input logic [15:0] l);
        @(posedge aclk);
        ev <= m;
        full <= f;
        acc <= (l != 16'h0);
        len <= l;
        @(posedge aclk);
        ev <= 7'h00;
        full <= 1'h0;
        acc <= 1'h0;
    endtask : pulse

    task automatic irq_is(input logic e);
        @(negedge aclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask : irq_is

    task automatic t_regs();
        rd(`HL2IG_OFS_LINK_EN, 32'h0, 2'h0);
        rd(`HL2IG_OFS_OVS_EN, 32'h0, 2'h0);
        rd(`HL2IG_OFS_LINK_STAT, 32'h0, 2'h0);
        wr(`HL2IG_OFS_LINK_EN, 32'hFFFFFFFF);
        rd(`HL2IG_OFS_LINK_EN, 32'h7F, 2'h0);
        wr(`HL2IG_OFS_OVS_EN, 32'hFF);
        rd(`HL2IG_OFS_OVS_EN, 32'h1, 2'h0);
        wr(`HL2IG_OFS_LINK_EN, 32'h0);
        wr(`HL2IG_OFS_OVS_EN, 32'h0);
        rd(`HL2IG_OFS_LINK_EN, 32'h0, 2'h0);
        rd(8'h10, 32'h0, `HL2IG_RESP_DECERR);
        // lane 0 strobe low, status writes and unmapped writes
        wr(`HL2IG_OFS_LINK_EN, 32'h7F, 4'hE);
        rd(`HL2IG_OFS_LINK_EN, 32'h0, 2'h0);
        wr(`HL2IG_OFS_LINK_STAT, 32'h7F);
        wr(`HL2IG_OFS_OVS_STAT, 32'h1);
        rd(`HL2IG_OFS_LINK_STAT, 32'h0, 2'h0);
        rd(`HL2IG_OFS_OVS_STAT, 32'h0, 2'h0);
        wr(8'h10, 32'h7F, 4'hF, `HL2IG_RESP_DECERR);
        rd(`HL2IG_OFS_LINK_EN, 32'h0, 2'h0);
    endtask : t_regs

    // reset in mid-run clears enables, flags and irq
    task automatic t_reset();
        wr(`HL2IG_OFS_LINK_EN, 32'h7F);
        wr(`HL2IG_OFS_OVS_EN, 32'h1);
        pulse(7'h7F, 1'h1, 16'hFFFF);
        irq_is(1'h1);
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        irq_is(1'h0);
        rd(`HL2IG_OFS_LINK_EN, 32'h0, 2'h0);
        rd(`HL2IG_OFS_OVS_EN, 32'h0, 2'h0);
        rd(`HL2IG_OFS_LINK_STAT, 32'h0, 2'h0);
        rd(`HL2IG_OFS_OVS_STAT, 32'h0, 2'h0);
    endtask : t_reset

    // each of the seven link sources: latched while disabled, then raised when enabled; buffer full only raised when enabled
    task automatic t_sources();
        logic [6:0] m;
        for (int i = 0; i < 7; i++) begin
            m = 7'h01 << i;
            wr(`HL2IG_OFS_LINK_EN, 32'h0);
            pulse(m, 1'h0, 16'h0);
            irq_is(1'h0);
            rd(`HL2IG_OFS_LINK_STAT, {25'h0, m}, 2'h0);
            wr(`HL2IG_OFS_LINK_EN, {25'h0, m});
            pulse(m, 1'h0, 16'h0);
            irq_is(1'h1);
            rd(`HL2IG_OFS_LINK_STAT, {25'h0, m}, 2'h0);
            irq_is(1'h0);
            rd(`HL2IG_OFS_LINK_STAT, 32'h0, 2'h0);
        end
        wr(`HL2IG_OFS_LINK_EN, 32'h8);
        pulse(7'h00, 1'h1, 16'h0);
        irq_is(1'h1);
        rd(`HL2IG_OFS_LINK_STAT, 32'h8, 2'h0);
    endtask : t_sources

    // oversize: the limit itself must not count
    task automatic t_ovs();
        wr(`HL2IG_OFS_LINK_EN, 32'h0);
        wr(`HL2IG_OFS_OVS_EN, 32'h1);
        pulse(7'h00, 1'h0, 16'h0114);
        irq_is(1'h0);
        pulse(7'h00, 1'h0, 16'h0115);
        irq_is(1'h1);
        rd(`HL2IG_OFS_OVS_STAT, 32'h1, 2'h0);
        irq_is(1'h0);
        rd(`HL2IG_OFS_OVS_STAT, 32'h0, 2'h0);
        wr(`HL2IG_OFS_OVS_EN, 32'h0);
        pulse(7'h00, 1'h0, 16'hFFFF);
        irq_is(1'h0);
        rd(`HL2IG_OFS_OVS_STAT, 32'h1, 2'h0);
    endtask : t_ovs

    task automatic final_report();
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    initial begin
        forever #2 aclk = ~aclk;
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_sources();
        t_ovs();
        t_reset();
        final_report();
    end

    // the whole run needs a few hundred cycles
    initial begin
        #40000;
        failures++;
        final_report();
    end
endmodule : hdlc_link2_interrupt_gating_tb_top
